//--- rcf_cfg.svh
// Constants for the reset cause flag block: widths, offsets, bit positions, reset values.
// Assumes it is included by bare name; definitions only.
`ifndef RCF_CFG_SVH
`define RCF_CFG_SVH

`define RCF_DATA_W        32
`define RCF_ADDR_W        8
`define RCF_STRB_W        4
`define RCF_FLAG_W        8
`define RCF_PAD_W         24
`define RCF_WORD_LSB      2
`define RCF_LANE0         0

`define RCF_OFF_CAUSE     8'h00
`define RCF_OFF_IRQ_STAT  8'h04
`define RCF_OFF_IRQ_MASK  8'h08

`define RCF_BIT_OVF       7
`define RCF_BIT_UNF       6
`define RCF_BIT_WIN       5
`define RCF_BIT_WDT       4
`define RCF_BIT_PIN       3
`define RCF_BIT_INSTR     2
`define RCF_BIT_PWRON     1
`define RCF_BIT_BROWN     0

`define RCF_CAUSE_INIT    8'h3c
`define RCF_BROWN_LOAD    8'h3c
`define RCF_BROWN_KEEP    8'h02
`define RCF_HW_SET_MASK   8'hc0
`define RCF_HW_CLR_MASK   8'h3f
`define RCF_FLAGS_ZERO    8'h00

`define RCF_RESP_OKAY     2'b00
`define RCF_RESP_SLVERR   2'b10
`define RCF_PIN_IDLE      1'b1

`endif

//--- rcf_pkg.sv
// Shared types of the reset cause flag block.
// Assumes rcf_cfg.svh is on the include path.
`include "rcf_cfg.svh"
package rcf_pkg;
	typedef logic [`RCF_FLAG_W-1:0] rcf_flags_type;
	typedef logic [`RCF_ADDR_W-1:0] rcf_addr_type;
	typedef logic [`RCF_DATA_W-1:0] rcf_data_type;
	typedef logic [`RCF_STRB_W-1:0] rcf_strb_type;
	typedef logic [1:0]             rcf_resp_type;
endpackage

//--- rcf_regbus_if.sv
// Internal register access bundle between the bus slave and the flag register file.
// Assumes both ends run on the same clock; wr_en and rd_en are one-cycle pulses.
`timescale 1ns/1ns
interface rcf_regbus_if;
	import rcf_pkg::*;
	logic         wr_en;
	rcf_addr_type wr_addr;
	rcf_data_type wr_data;
	rcf_strb_type wr_strb;
	logic         wr_err;
	logic         rd_en;
	rcf_addr_type rd_addr;
	rcf_data_type rd_data;
	logic         rd_err;

	// Bus side drives requests, register side answers
	modport bus  (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_err,
		output rd_en, output rd_addr, input rd_data, input rd_err);
	modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_err,
		input rd_en, input rd_addr, output rd_data, output rd_err);
endinterface

//--- rcf_pin_sync.sv
// Two flip-flop synchroniser for one asynchronous pin level.
// Assumes the pin idles high; only the second stage may be read outside.
`timescale 1ns/1ns
`include "rcf_cfg.svh"
module rcf_pin_sync (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_q
);
	logic meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= `RCF_PIN_IDLE;
			sync_q <= `RCF_PIN_IDLE;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule

//--- rcf_axil_slave.sv
// AXI4-Lite slave front end: takes one write and one read at a time and hands them on as pulses.
// Assumes the register side answers rd_data, rd_err and wr_err combinationally.
`timescale 1ns/1ns
`include "rcf_cfg.svh"
module rcf_axil_slave
	import rcf_pkg::*;
(
	input  wire logic   clock,
	input  wire logic   rst,
	input  wire logic   s_axi_awvalid,
	input  rcf_addr_type s_axi_awaddr,
	output logic        s_axi_awready,
	input  wire logic   s_axi_wvalid,
	input  rcf_data_type s_axi_wdata,
	input  rcf_strb_type s_axi_wstrb,
	output logic        s_axi_wready,
	output logic        s_axi_bvalid,
	output rcf_resp_type s_axi_bresp,
	input  wire logic   s_axi_bready,
	input  wire logic   s_axi_arvalid,
	input  rcf_addr_type s_axi_araddr,
	output logic        s_axi_arready,
	output logic        s_axi_rvalid,
	output rcf_data_type s_axi_rdata,
	output rcf_resp_type s_axi_rresp,
	input  wire logic   s_axi_rready,
	rcf_regbus_if.bus   rb
);
	logic         aw_held_q;
	logic         w_held_q;
	rcf_addr_type addr_q;
	rcf_data_type data_q;
	rcf_strb_type strb_q;

	// Handshake terms
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_held_q & w_held_q;
	wire b_done  = s_axi_bvalid & s_axi_bready;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire r_done  = s_axi_rvalid & s_axi_rready;

	// Requests towards the register file
	assign rb.wr_en   = wr_fire;
	assign rb.wr_addr = addr_q;
	assign rb.wr_data = data_q;
	assign rb.wr_strb = strb_q;
	assign rb.rd_en   = ar_take;
	assign rb.rd_addr = s_axi_araddr;

	// Write path: address and data in either order, response after both
	always_ff @(posedge clock) begin
		if (rst) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			addr_q        <= '0;
			data_q        <= '0;
			strb_q        <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RCF_RESP_OKAY;
		end else begin
			aw_held_q     <= (aw_held_q | aw_take) & ~wr_fire;
			w_held_q      <= (w_held_q | w_take) & ~wr_fire;
			addr_q        <= aw_take ? s_axi_awaddr : addr_q;
			data_q        <= w_take ? s_axi_wdata : data_q;
			strb_q        <= w_take ? s_axi_wstrb : strb_q;
			s_axi_awready <= (s_axi_awready & ~aw_take) | b_done;
			s_axi_wready  <= (s_axi_wready & ~w_take) | b_done;
			s_axi_bvalid  <= wr_fire | (s_axi_bvalid & ~s_axi_bready);
			s_axi_bresp   <= wr_fire ? (rb.wr_err ? `RCF_RESP_SLVERR : `RCF_RESP_OKAY) : s_axi_bresp;
		end
	end

	// Read path: data latched at the address handshake
	always_ff @(posedge clock) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `RCF_RESP_OKAY;
		end else begin
			s_axi_arready <= (s_axi_arready & ~ar_take) | r_done;
			s_axi_rvalid  <= ar_take | (s_axi_rvalid & ~s_axi_rready);
			s_axi_rdata   <= ar_take ? rb.rd_data : s_axi_rdata;
			s_axi_rresp   <= ar_take ? (rb.rd_err ? `RCF_RESP_SLVERR : `RCF_RESP_OKAY) : s_axi_rresp;
		end
	end
endmodule

//--- rcf_top.sv
// Reset cause flag register with AXI4-Lite access, event status, mask and interrupt.
// Assumes event inputs are one-cycle pulses from logic on the same clock; the pin is asynchronous.
`timescale 1ns/1ns
`include "rcf_cfg.svh"
module rcf_top
	import rcf_pkg::*;
(
	input  wire logic    clock,
	input  wire logic    rst,
	input  wire logic    s_axi_awvalid,
	input  rcf_addr_type s_axi_awaddr,
	output logic         s_axi_awready,
	input  wire logic    s_axi_wvalid,
	input  rcf_data_type s_axi_wdata,
	input  rcf_strb_type s_axi_wstrb,
	output logic         s_axi_wready,
	output logic         s_axi_bvalid,
	output rcf_resp_type s_axi_bresp,
	input  wire logic    s_axi_bready,
	input  wire logic    s_axi_arvalid,
	input  rcf_addr_type s_axi_araddr,
	output logic         s_axi_arready,
	output logic         s_axi_rvalid,
	output rcf_data_type s_axi_rdata,
	output rcf_resp_type s_axi_rresp,
	input  wire logic    s_axi_rready,
	input  wire logic    stack_overflow_evt,
	input  wire logic    stack_underflow_evt,
	input  wire logic    stack_reset_enable,
	input  wire logic    watchdog_clear_instr,
	input  wire logic    window_armed,
	input  wire logic    window_open,
	input  wire logic    watchdog_timeout_evt,
	input  wire logic    external_reset_pin_n,
	input  wire logic    reset_instr_evt,
	input  wire logic    power_on_evt,
	input  wire logic    brown_out_evt,
	output rcf_flags_type reset_cause_register_q,
	output logic         device_reset_q,
	output logic         irq_q
);
	// True when a byte address falls on the word of a register
	function automatic logic addr_hit(input rcf_addr_type addr, input rcf_addr_type off);
		addr_hit = (addr[`RCF_ADDR_W-1:`RCF_WORD_LSB] == off[`RCF_ADDR_W-1:`RCF_WORD_LSB]);
	endfunction

	rcf_flags_type irq_stat_q;
	rcf_flags_type irq_stat_d;
	rcf_flags_type irq_mask_q;
	rcf_flags_type irq_mask_d;
	rcf_flags_type cause_d;
	logic          pin_sync;
	logic          pin_prev_q;
	logic          irq_d;

	rcf_regbus_if rb_if();

	// Bus front end
	rcf_axil_slave u_slave (
		.clock         (clock),
		.rst           (rst),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awready (s_axi_awready),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bready  (s_axi_bready),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arready (s_axi_arready),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rready  (s_axi_rready),
		.rb            (rb_if.bus)
	);

	// External reset pin enters through two flops
	rcf_pin_sync u_pin_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (external_reset_pin_n),
		.sync_q   (pin_sync)
	);

	// Address decode for writes and reads
	wire hit_wr_cause = addr_hit(rb_if.wr_addr, `RCF_OFF_CAUSE);
	wire hit_wr_stat  = addr_hit(rb_if.wr_addr, `RCF_OFF_IRQ_STAT);
	wire hit_wr_mask  = addr_hit(rb_if.wr_addr, `RCF_OFF_IRQ_MASK);
	wire hit_rd_cause = addr_hit(rb_if.rd_addr, `RCF_OFF_CAUSE);
	wire hit_rd_stat  = addr_hit(rb_if.rd_addr, `RCF_OFF_IRQ_STAT);
	wire hit_rd_mask  = addr_hit(rb_if.rd_addr, `RCF_OFF_IRQ_MASK);
	wire lane0        = rb_if.wr_strb[`RCF_LANE0];

	// Register write strobes, only the low byte lane carries flags
	wire cause_wr = rb_if.wr_en & hit_wr_cause & lane0;
	wire stat_wr  = rb_if.wr_en & hit_wr_stat & lane0;
	wire mask_wr  = rb_if.wr_en & hit_wr_mask & lane0;
	wire rcf_flags_type wr_flags = rb_if.wr_data[`RCF_FLAG_W-1:0];

	// Unmapped addresses answer with a slave error
	assign rb_if.wr_err = ~(hit_wr_cause | hit_wr_stat | hit_wr_mask);
	assign rb_if.rd_err = ~(hit_rd_cause | hit_rd_stat | hit_rd_mask);

	// Read selection, upper bits read as zero
	wire rcf_flags_type rd_flags = hit_rd_cause ? reset_cause_register_q :
	                               hit_rd_stat  ? irq_stat_q :
	                               hit_rd_mask  ? irq_mask_q : `RCF_FLAGS_ZERO;
	assign rb_if.rd_data = {`RCF_PAD_W'h0, rd_flags};

	// Pin reset is taken on the falling edge of the synchronised level
	wire pin_fall = pin_prev_q & ~pin_sync;

	// Stack events count only while stack resets are enabled
	wire ovf_ev = stack_overflow_evt & stack_reset_enable;
	wire unf_ev = stack_underflow_evt & stack_reset_enable;

	// A watchdog clear before arming or outside the window is a violation
	wire win_ev = watchdog_clear_instr & (~window_armed | ~window_open);

	// Event vector in flag layout, one per cause
	wire rcf_flags_type ev;
	assign ev[`RCF_BIT_OVF]   = ovf_ev;
	assign ev[`RCF_BIT_UNF]   = unf_ev;
	assign ev[`RCF_BIT_WIN]   = win_ev;
	assign ev[`RCF_BIT_WDT]   = watchdog_timeout_evt;
	assign ev[`RCF_BIT_PIN]   = pin_fall;
	assign ev[`RCF_BIT_INSTR] = reset_instr_evt;
	assign ev[`RCF_BIT_PWRON] = power_on_evt;
	assign ev[`RCF_BIT_BROWN] = brown_out_evt;
	wire any_ev = |ev;

	// Firmware write forms the base value; untouched flags keep their state
	wire rcf_flags_type fw_base = cause_wr ? wr_flags : reset_cause_register_q;
	// Power-on loads the full initial pattern
	wire rcf_flags_type pwr_base = power_on_evt ? `RCF_CAUSE_INIT : fw_base;
	// Brown-out loads the pattern but keeps the power-on flag
	wire rcf_flags_type brn_base = brown_out_evt ?
	                               ((pwr_base & `RCF_BROWN_KEEP) | `RCF_BROWN_LOAD) : pwr_base;
	// Hardware events win over a firmware write in the same cycle
	assign cause_d = (brn_base | (ev & `RCF_HW_SET_MASK)) & ~(ev & `RCF_HW_CLR_MASK);

	// Sticky event status, cleared by writing one, new events win
	assign irq_stat_d = ((stat_wr ? ~wr_flags : irq_stat_q) & irq_stat_q) | ev;
	assign irq_mask_d = mask_wr ? wr_flags : irq_mask_q;
	assign irq_d      = |(irq_stat_d & irq_mask_d);

	// Cause flags; bus reset acts as a power-on
	always_ff @(posedge clock) begin
		if (rst) begin
			reset_cause_register_q <= `RCF_CAUSE_INIT;
		end else begin
			reset_cause_register_q <= cause_d;
		end
	end

	// Interrupt status, mask and output
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_stat_q <= `RCF_FLAGS_ZERO;
			irq_mask_q <= `RCF_FLAGS_ZERO;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq_q      <= irq_d;
		end
	end

	// Reset request pulse and pin edge history
	always_ff @(posedge clock) begin
		if (rst) begin
			device_reset_q <= 1'b0;
			pin_prev_q     <= `RCF_PIN_IDLE;
		end else begin
			device_reset_q <= any_ev;
			pin_prev_q     <= pin_sync;
		end
	end

	// Checks on the flag, status, interrupt and bus behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Overflow with enable sets the flag and holds it without a write
	ovf_sticky_a: assert property (
		stack_overflow_evt && stack_reset_enable && !power_on_evt && !brown_out_evt
		|=> reset_cause_register_q[`RCF_BIT_OVF] ##1
		    (reset_cause_register_q[`RCF_BIT_OVF] || $past(cause_wr) || $past(power_on_evt)
		     || $past(brown_out_evt)))
		else $error("overflow flag not set or not held");

	// Underflow with enable sets its flag
	unf_set_a: assert property (
		stack_underflow_evt && stack_reset_enable && !power_on_evt && !brown_out_evt
		|=> reset_cause_register_q[`RCF_BIT_UNF])
		else $error("underflow flag not set");

	// Watchdog clear outside an armed open window clears the flag
	win_clear_a: assert property (
		watchdog_clear_instr && (!window_armed || !window_open) && !power_on_evt
		|=> !reset_cause_register_q[`RCF_BIT_WIN])
		else $error("window violation flag not cleared");

	// Watchdog clear inside the open armed window leaves the flag alone
	win_keep_a: assert property (
		watchdog_clear_instr && window_armed && window_open && !cause_wr
		&& !power_on_evt && !brown_out_evt
		|=> $stable(reset_cause_register_q[`RCF_BIT_WIN]))
		else $error("window flag changed on a legal watchdog clear");

	// Time-out clears the watchdog flag
	wdt_clear_a: assert property (
		watchdog_timeout_evt && !power_on_evt && !brown_out_evt
		|=> !reset_cause_register_q[`RCF_BIT_WDT])
		else $error("watchdog flag not cleared");

	// Pin assertion clears the pin flag one cycle after the synchronised level falls
	pin_clear_a: assert property (
		$fell(pin_sync) && !power_on_evt && !brown_out_evt
		|=> !reset_cause_register_q[`RCF_BIT_PIN])
		else $error("pin reset flag not cleared");

	// Reset instruction clears its flag and requests a reset
	instr_clear_a: assert property (
		reset_instr_evt && !power_on_evt && !brown_out_evt
		|=> !reset_cause_register_q[`RCF_BIT_INSTR] && device_reset_q)
		else $error("instruction flag not cleared or no reset");

	// Power-on loads the initial pattern
	pwron_load_a: assert property (
		power_on_evt && !stack_overflow_evt && !stack_underflow_evt && !watchdog_timeout_evt
		&& !win_ev && !pin_fall && !reset_instr_evt && !brown_out_evt
		|=> reset_cause_register_q == `RCF_CAUSE_INIT)
		else $error("power-on pattern wrong");

	// Brown-out loads its pattern and keeps the power-on flag
	brown_load_a: assert property (
		brown_out_evt && !power_on_evt && !ovf_ev && !unf_ev && !win_ev
		&& !watchdog_timeout_evt && !pin_fall && !reset_instr_evt && !cause_wr
		|=> ((reset_cause_register_q & ~`RCF_BROWN_KEEP) == `RCF_BROWN_LOAD)
		    && (reset_cause_register_q[`RCF_BIT_PWRON] == $past(reset_cause_register_q[`RCF_BIT_PWRON])))
		else $error("brown-out pattern wrong");

	// A firmware write without events lands as written
	fw_write_a: assert property (
		cause_wr && !any_ev
		|=> reset_cause_register_q == $past(wr_flags))
		else $error("firmware write not stored");

	// Stack events without enable change nothing and request no reset
	stack_gate_a: assert property (
		(stack_overflow_evt || stack_underflow_evt) && !stack_reset_enable
		&& !win_ev && !watchdog_timeout_evt && !pin_fall && !reset_instr_evt
		&& !power_on_evt && !brown_out_evt && !cause_wr
		|=> $stable(reset_cause_register_q) && !device_reset_q)
		else $error("stack event acted while disabled");

	// Quiet cycles keep every flag
	flags_keep_a: assert property (
		!any_ev && !cause_wr
		|=> $stable(reset_cause_register_q))
		else $error("flags changed without cause");

	// Every cause raises the status bit and the reset pulse together
	event_track_a: assert property (
		any_ev
		|=> device_reset_q && ((irq_stat_q & $past(ev)) == $past(ev)))
		else $error("event lost in status or reset");

	// Interrupt follows the masked status
	irq_level_a: assert property (
		irq_q == |(irq_stat_q & irq_mask_q))
		else $error("interrupt level wrong");

	// Underflow flag stays set until firmware or power events
	unf_hold_a: assert property (
		reset_cause_register_q[`RCF_BIT_UNF] && !cause_wr && !power_on_evt && !brown_out_evt
		|=> reset_cause_register_q[`RCF_BIT_UNF])
		else $error("underflow flag lost");

	// Cleared pin flag stays low until firmware or power events
	pin_hold_a: assert property (
		!reset_cause_register_q[`RCF_BIT_PIN] && !cause_wr && !power_on_evt && !brown_out_evt
		|=> !reset_cause_register_q[`RCF_BIT_PIN])
		else $error("pin reset flag came back");

	// Only flags whose event fired may change
	other_keep_a: assert property (
		any_ev && !cause_wr && !power_on_evt && !brown_out_evt
		|=> ((reset_cause_register_q ^ $past(reset_cause_register_q)) & ~$past(ev)) == `RCF_FLAGS_ZERO)
		else $error("unrelated flag changed");

	// No reset request without a cause
	pulse_only_a: assert property (
		!any_ev |=> !device_reset_q)
		else $error("reset request without cause");

	// Write response stands until taken
	bvalid_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");

	// Read data stand until taken
	rvalid_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped early");

	// Write answer follows the register update with the decode result
	write_answer_a: assert property (
		rb_if.wr_en |=> s_axi_bvalid && ((s_axi_bresp == `RCF_RESP_SLVERR) == $past(rb_if.wr_err)))
		else $error("write answer wrong");

	// Read answer carries the word selected at the address handshake
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && (s_axi_rdata == $past(rb_if.rd_data))
		&& ((s_axi_rresp == `RCF_RESP_SLVERR) == $past(rb_if.rd_err)))
		else $error("read answer wrong");

	// Writing ones clears status bits when no event competes
	stat_clear_a: assert property (
		stat_wr && !any_ev |=> irq_stat_q == ($past(irq_stat_q) & ~$past(wr_flags)))
		else $error("status clear wrong");

	// Mask takes the written value
	mask_store_a: assert property (
		mask_wr |=> irq_mask_q == $past(wr_flags))
		else $error("mask write not stored");
endmodule

//--- rcf_evt_model.sv
// Behavioural model of the reset event sources that face the flag block.
// Assumes the bench asks for one event at a time, with go held for one cycle.
`timescale 1ns/1ns
module rcf_evt_model (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [2:0] sel,
	output logic [7:0]      evt_q,
	output logic            pin_n
);
	logic [3:0] pin_cnt_q;

	// One-cycle pulse on the chosen source; the pin is held low for a stretch
	always_ff @(posedge clock) begin
		if (rst) begin
			evt_q     <= 8'h00;
			pin_cnt_q <= 4'h0;
		end else begin
			evt_q <= go ? (8'h01 << sel) : 8'h00;
			if (go && sel == 3'h4) begin
				pin_cnt_q <= 4'h8;
			end else if (pin_cnt_q != 4'h0) begin
				pin_cnt_q <= pin_cnt_q - 4'h1;
			end
		end
	end

	// Pin idles high through its pull-up
	assign pin_n = (pin_cnt_q == 4'h0);
endmodule

//--- tb.sv
// Self-checking bench for the reset cause flag block over AXI4-Lite.
// Assumes the event model drives the cause inputs; the bench acts as firmware.
`timescale 1ns/1ns
`include "rcf_cfg.svh"
module tb;
	import rcf_pkg::*;
	logic          clock, rst, awvalid, wvalid, bready, arvalid, rready;
	logic          awready, wready, bvalid, arready, rvalid, irq, dev_rst;
	logic          stk_en, win_armed, win_open, go;
	logic [2:0]    sel;
	logic [7:0]    evt;
	logic          pin_n;
	rcf_addr_type  awaddr, araddr;
	rcf_data_type  wdata, rdata, rd;
	rcf_strb_type  wstrb;
	rcf_resp_type  bresp, rresp, resp;
	rcf_flags_type cause, exp_f, exp_s;
	int            err_total, n_checks, k;

	rcf_top uut (.clock(clock), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awaddr(awaddr),
		.s_axi_awready(awready), .s_axi_wvalid(wvalid), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bresp(bresp), .s_axi_bready(bready),
		.s_axi_arvalid(arvalid), .s_axi_araddr(araddr), .s_axi_arready(arready),
		.s_axi_rvalid(rvalid), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rready(rready),
		.stack_overflow_evt(evt[0]), .stack_underflow_evt(evt[1]), .stack_reset_enable(stk_en),
		.watchdog_clear_instr(evt[2]), .window_armed(win_armed), .window_open(win_open),
		.watchdog_timeout_evt(evt[3]), .external_reset_pin_n(pin_n), .reset_instr_evt(evt[5]),
		.power_on_evt(evt[6]), .brown_out_evt(evt[7]), .reset_cause_register_q(cause),
		.device_reset_q(dev_rst), .irq_q(irq));

	rcf_evt_model model (.clock(clock), .rst(rst), .go(go), .sel(sel), .evt_q(evt), .pin_n(pin_n));

	// Clock at 125 MHz
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Verdict and end of run
	task automatic finish_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Compare one value and count it
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", name, e, g);
			err_total++;
		end
	endtask

	// Out of time on a bus wait
	task automatic hang(input string name);
		$display("Error %s expected answer seen timeout", name);
		err_total++;
		finish_test();
	endtask

	// One AXI4-Lite write; address and data offered together
	task automatic wr(input rcf_addr_type a, input rcf_data_type d, input rcf_strb_type s, output rcf_resp_type r);
		int i;
		@(posedge clock);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		bready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				return;
			end
		end
		hang("write");
	endtask

	// One AXI4-Lite read
	task automatic rdw(input rcf_addr_type a, output rcf_data_type d, output rcf_resp_type r);
		int i;
		@(posedge clock);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				return;
			end
		end
		hang("read");
	endtask

	// Read a register and compare word and response
	task automatic rchk(input string name, input rcf_addr_type a, input rcf_flags_type e);
		rdw(a, rd, resp);
		chk(name, {24'h000000, e}, rd);
		chk("rresp", `RCF_RESP_OKAY, resp);
	endtask

	// Write a full word and expect OKAY
	task automatic wok(input rcf_addr_type a, input rcf_flags_type v);
		wr(a, {24'h000000, v}, 4'hf, resp);
		chk("bresp", `RCF_RESP_OKAY, resp);
	endtask

	// Fire one event through the model, then check the flags
	task automatic fire(input int e, input logic upd);
		int n;
		n = 0;
		@(posedge clock);
		go  <= 1'b1;
		sel <= e[2:0];
		@(posedge clock);
		go <= 1'b0;
		// Count the cycles in which the reset request stands
		repeat (12) begin
			@(posedge clock);
			if (dev_rst === 1'b1) n++;
		end
		if (upd) begin
			exp_s[7 - e] = 1'b1;
			case (e)
				0: exp_f = exp_f | 8'h80;
				1: exp_f = exp_f | 8'h40;
				2: exp_f = exp_f & 8'hdf;
				3: exp_f = exp_f & 8'hef;
				4: exp_f = exp_f & 8'hf7;
				5: exp_f = exp_f & 8'hfb;
				6: exp_f = 8'h3c;
				default: exp_f = {6'b001111, exp_f[1], 1'b0};
			endcase
		end
		chk("cause port", exp_f, cause);
		chk("reset pulse", upd, n);
		rchk("cause reg", `RCF_OFF_CAUSE, exp_f);
	endtask

	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, go} = 6'h00;
		{awaddr, araddr, wdata, wstrb, sel} = '0;
		{stk_en, win_armed, win_open} = 3'b011;
		err_total = 0;
		n_checks  = 0;
		exp_s     = 8'h00;
		rst       = 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		exp_f = `RCF_CAUSE_INIT;
		rchk("cause reset", `RCF_OFF_CAUSE, 8'h3c);
		rchk("status reset", `RCF_OFF_IRQ_STAT, 8'h00);
		rchk("mask reset", `RCF_OFF_IRQ_MASK, 8'h00);
		// Firmware re-arms every active-low flag
		wok(`RCF_OFF_CAUSE, 8'h3f);
		exp_f = 8'h3f;
		rchk("cause rearm", `RCF_OFF_CAUSE, 8'h3f);
		for (k = 0; k < 2; k++) fire(k, 1'b0);
		stk_en <= 1'b1;
		fire(2, 1'b0);
		{win_armed, win_open} <= 2'b00;
		for (k = 0; k < 6; k++) fire(k, 1'b1);
		wok(`RCF_OFF_CAUSE, 8'h3f);
		exp_f = 8'h3f;
		// Watchdog clear with the window armed but shut
		{win_armed, win_open} <= 2'b10;
		fire(2, 1'b1);
		fire(7, 1'b1);
		fire(6, 1'b1);
		wok(`RCF_OFF_CAUSE, 8'h03);
		exp_f = 8'h03;
		rchk("cause fw", `RCF_OFF_CAUSE, 8'h03);
		// Disabled byte lane writes nothing
		wr(`RCF_OFF_CAUSE, 32'h000000ff, 4'h0, resp);
		chk("bresp strb", `RCF_RESP_OKAY, resp);
		rchk("cause strb", `RCF_OFF_CAUSE, 8'h03);
		// Unmapped address
		wr(8'h0c, 32'h000000ff, 4'hf, resp);
		chk("bresp unmapped", `RCF_RESP_SLVERR, resp);
		rdw(8'h0c, rd, resp);
		chk("rresp unmapped", `RCF_RESP_SLVERR, resp);
		chk("rdata unmapped", 32'h00000000, rd);
		// Status, mask and interrupt
		rchk("status all", `RCF_OFF_IRQ_STAT, exp_s);
		chk("irq masked", 1'b0, irq);
		wok(`RCF_OFF_IRQ_MASK, 8'h04);
		repeat (2) @(posedge clock);
		chk("irq on", 1'b1, irq);
		wok(`RCF_OFF_IRQ_STAT, 8'hfb);
		rchk("status w1c", `RCF_OFF_IRQ_STAT, 8'h04);
		chk("irq held", 1'b1, irq);
		wok(`RCF_OFF_IRQ_MASK, 8'h00);
		repeat (2) @(posedge clock);
		chk("irq mask off", 1'b0, irq);
		wok(`RCF_OFF_IRQ_MASK, 8'h04);
		wok(`RCF_OFF_IRQ_STAT, 8'h04);
		repeat (2) @(posedge clock);
		chk("irq cleared", 1'b0, irq);
		rchk("status clear", `RCF_OFF_IRQ_STAT, 8'h00);
		// Bus reset in mid-run acts as a power-on of the flags
		rst <= 1'b1;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rchk("cause rst", `RCF_OFF_CAUSE, 8'h3c);
		rchk("mask rst", `RCF_OFF_IRQ_MASK, 8'h00);
		finish_test();
	end
endmodule
